/* tav_regs.svh */
/*
 constants for the teletext ancillary packet inserter: byte values,
 byte positions, packet types and lengths.
 assumes it is included by bare name wherever the numbers are needed.
*/
`ifndef TAV_REGS_SVH
`define TAV_REGS_SVH

// preamble and fixed bytes
`define TAV_PREAMBLE_0 8'h00
`define TAV_PREAMBLE_1 8'hFF
`define TAV_SECONDARY_ID 8'h80
`define TAV_FILL_BYTE 8'h80
`define TAV_DID_FIXED 3'h2
`define TAV_WC_TTX 6'h0B
`define TAV_WC_DUMMY 6'h00

// byte positions, counted from 1
`define TAV_POS_DID 6'h04
`define TAV_POS_SDID 6'h05
`define TAV_POS_WC 6'h06
`define TAV_POS_LINE 6'h07
`define TAV_POS_INTID 6'h08
`define TAV_POS_DATA0 6'h09
`define TAV_POS_DATAN 6'h32
`define TAV_POS_CSUM 6'h33
`define TAV_POS_FILL 6'h34
`define TAV_DUMMY_LEN 6'h06

// packet type codes, field bit sits above them
`define TAV_TYPE_START 2'h0
`define TAV_TYPE_VBI 2'h1
`define TAV_TYPE_END 2'h2
`define TAV_TYPE_FULL 2'h3

// line numbers
`define TAV_VBI_LAST_LINE 9'h017

// payload bytes held per line
`define TAV_PAYLOAD_BYTES 42
`define TAV_PAYLOAD_LAST 6'h29

`endif

/* tav_pkg.sv */
/*
 types of the teletext ancillary packet inserter.
 assumes tav_regs.svh supplies the numeric constants.
*/
package tav_pkg;

    typedef struct packed {
        logic hsync;
        logic vsync;
        logic active_video_flag;
    } tav_sync_t;

    typedef struct packed {
        logic [8:0] line;
        logic hamming_err;
        logic parity_err;
        logic packet_code_error;
        logic match2;
        logic match1;
    } tav_ttx_meta_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] data;
    } tav_ttx_wr_t;

    typedef enum logic [1:0] {
        TAV_ST_IDLE = 2'b00,
        TAV_ST_SEND = 2'b01
    } tav_state_t;

endpackage

/* tav_inserter.sv */
/*
 teletext ancillary packet inserter: buffers one sliced 625-line
 teletext line and inserts it, plus dummy timing packets, on the luma
 bus during the horizontal blanking that follows.
 assumes video timing and slicer strobes come from logic on i_ref_clk;
 only i_rst_b is asynchronous.
*/
// Behaviour
// - sliced packet goes out on luma bus in blanking after its line
// - teletext packet is 52 bytes: header, line, id, 42 data, checksum, fill
// - dummy timing packet is six bytes ending 0x80, 0x80
// - teletext word count byte is 0x4B with parity on top
// - id, word count and checksum carry even parity and its inverse
// - checksum is low six bits of sum of data bytes
// - first field start gives dummy packet with id 0x50
// - first field lines 1 to 23 use id 0x91
// - first field line 23 dummy packet uses id 0x92
// - first field line 24 onward uses id 0x53
// - second field start gives dummy packet with id 0x94
// - second field lines 1 to 23 use id 0x55
// - second field line 23 dummy packet uses id 0x56
// - second field line 24 onward uses id 0x97
// - every field gets a dummy packet after line 23
// - line 23 teletext goes ahead of line 23 dummy packet
// - low reset input holds every register at its reset value
// - luma, syncs and active video float during and right after reset
`timescale 1ns/1ps
`include "tav_regs.svh"

module tav_inserter (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_luma,
    input wire tav_pkg::tav_sync_t i_sync,
    input wire logic i_field,
    input wire logic i_hblank_start,
    input wire logic [8:0] i_line_done,
    input wire tav_pkg::tav_ttx_wr_t i_ttx_wr,
    input wire logic i_ttx_done,
    input wire tav_pkg::tav_ttx_meta_t i_ttx_meta,
    output logic [7:0] o_luma,
    output tav_pkg::tav_sync_t o_sync,
    output logic o_video_oe_b,
    output logic o_busy
);

    // payload store; written by the slicer during the active line
    logic [7:0] payload [0:`TAV_PAYLOAD_BYTES-1];
    tav_pkg::tav_ttx_meta_t meta;
    logic ttx_pending;
    logic last_field;
    logic field_seen;

    // packets queued for the current blanking interval
    logic need_start;
    logic need_ttx;
    logic need_end;
    logic field_now;

    tav_pkg::tav_state_t state;
    logic [1:0] pkt_type;
    logic pkt_is_dummy;
    logic [5:0] pos;
    logic [7:0] csum;

    logic [7:0] next_byte;
    logic [5:0] last_pos;
    logic pick_any;
    logic [1:0] pick_type;
    logic pick_dummy;
    logic [2:0] did_code;
    logic field_change;
    logic line23;

    // even parity over bits 5:0 in bit 6, inverse in bit 7
    function automatic logic [7:0] par6(input logic [5:0] v);
        logic even_parity_bit;
        even_parity_bit = ^v;
        return {~even_parity_bit, even_parity_bit, v};
    endfunction

    assign field_change = i_hblank_start && (!field_seen || (i_field != last_field));
    assign line23 = (i_line_done == `TAV_VBI_LAST_LINE);

    // payload capture; cleared in reset so no stale line survives it
    generate
        for (genvar gi = 0; gi < `TAV_PAYLOAD_BYTES; gi++) begin : g_pay
            always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    payload[gi] <= 8'h00;
                end else if (i_ttx_wr.we && (i_ttx_wr.addr == 6'(gi))) begin
                    payload[gi] <= i_ttx_wr.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= '0;
        end else if (i_ttx_done) begin
            meta <= i_ttx_meta;
        end
    end

    // pending flag: a new line wins over the clear at hblank
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ttx_pending <= 1'b0;
        end else if (i_ttx_done) begin
            ttx_pending <= 1'b1;
        end else if (i_hblank_start) begin
            ttx_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_field <= 1'b0;
            field_seen <= 1'b0;
        end else if (i_hblank_start) begin
            last_field <= i_field;
            field_seen <= 1'b1;
        end
    end

    // queue for this blanking; start dummy, teletext, then line 23 dummy
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            need_start <= 1'b0;
            need_ttx <= 1'b0;
            need_end <= 1'b0;
            field_now <= 1'b0;
        end else if (i_hblank_start) begin
            need_start <= field_change;
            need_ttx <= ttx_pending;
            need_end <= line23;
            field_now <= i_field;
        end else if (state == tav_pkg::TAV_ST_IDLE && pick_any) begin
            if (need_start) begin
                need_start <= 1'b0;
            end else if (need_ttx) begin
                need_ttx <= 1'b0;
            end else begin
                need_end <= 1'b0;
            end
        end
    end

    // next packet in priority order
    always_comb begin
        pick_any = need_start || need_ttx || need_end;
        pick_dummy = 1'b1;
        pick_type = `TAV_TYPE_END;
        if (need_start) begin
            pick_type = `TAV_TYPE_START;
        end else if (need_ttx) begin
            pick_dummy = 1'b0;
            if (meta.line <= `TAV_VBI_LAST_LINE) begin
                pick_type = `TAV_TYPE_VBI;
            end else begin
                pick_type = `TAV_TYPE_FULL;
            end
        end
    end

    assign last_pos = pkt_is_dummy ? `TAV_DUMMY_LEN : `TAV_POS_FILL;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= tav_pkg::TAV_ST_IDLE;
            pkt_type <= `TAV_TYPE_START;
            pkt_is_dummy <= 1'b1;
            pos <= 6'h01;
        end else begin
            unique case (state)
                tav_pkg::TAV_ST_IDLE: begin
                    if (pick_any && !i_hblank_start) begin
                        state <= tav_pkg::TAV_ST_SEND;
                        pkt_type <= pick_type;
                        pkt_is_dummy <= pick_dummy;
                        pos <= 6'h01;
                    end
                end
                tav_pkg::TAV_ST_SEND: begin
                    if (pos == last_pos) begin
                        state <= tav_pkg::TAV_ST_IDLE;
                    end
                    pos <= pos + 6'h01;
                end
            endcase
        end
    end

    // running checksum over the data bytes
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            csum <= 8'h00;
        end else if (state == tav_pkg::TAV_ST_IDLE) begin
            csum <= 8'h00;
        end else if (pos >= `TAV_POS_DATA0 && pos <= `TAV_POS_DATAN) begin
            csum <= csum + next_byte;
        end
    end

    assign did_code = {field_now, pkt_type};

    // byte at the current position
    always_comb begin
        next_byte = `TAV_FILL_BYTE;
        if (pos == 6'h01) begin
            next_byte = `TAV_PREAMBLE_0;
        end else if (pos <= 6'h03) begin
            next_byte = `TAV_PREAMBLE_1;
        end else if (pos == `TAV_POS_DID) begin
            next_byte = par6({`TAV_DID_FIXED, did_code});
        end else if (pos == `TAV_POS_SDID) begin
            next_byte = `TAV_SECONDARY_ID;
        end else if (pos == `TAV_POS_WC) begin
            if (pkt_is_dummy) begin
                next_byte = par6(`TAV_WC_DUMMY);
            end else begin
                next_byte = par6(`TAV_WC_TTX);
            end
        end else if (pos == `TAV_POS_LINE) begin
            next_byte = meta.line[7:0];
        end else if (pos == `TAV_POS_INTID) begin
            next_byte = {2'b00, meta.hamming_err, meta.parity_err,
                meta.packet_code_error, meta.match2, meta.match1,
                meta.line[8]};
        end else if (pos <= `TAV_POS_DATAN) begin
            next_byte = payload[pos - `TAV_POS_DATA0];
        end else if (pos == `TAV_POS_CSUM) begin
            next_byte = par6(csum[5:0]);
        end
    end

    // output pins, floated until the first field start after reset
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_video_oe_b <= 1'b1;
        end else if (field_change) begin
            o_video_oe_b <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_luma <= 8'h00;
            o_sync <= '0;
            o_busy <= 1'b0;
        end else begin
            o_sync <= i_sync;
            o_busy <= (state == tav_pkg::TAV_ST_SEND);
            if (state == tav_pkg::TAV_ST_SEND) begin
                o_luma <= next_byte;
            end else begin
                o_luma <= i_luma;
            end
        end
    end

endmodule

/* tav_rx_model.sv */
/*
 receiver model: records every packet byte seen on the luma bus.
 assumes o_busy marks packet bytes, one per clock.
*/
`timescale 1ns/1ps
module tav_rx_model (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_luma,
    input wire logic i_busy
);
    logic [7:0] mem [0:1023];
    int wp;
    // picture bytes are dropped, only ancillary bytes are kept
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp <= 0;
        end else if (i_busy) begin
            mem[wp] <= i_luma;
            wp <= wp + 1;
        end
    end
endmodule

/* tav_inserter_asserts.sv */
/*
 checker for the inserter's output stream.
 assumes one clock domain and an active low asynchronous reset.
*/
`timescale 1ns/1ps
module tav_inserter_asserts (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_luma,
    input wire tav_pkg::tav_sync_t i_sync,
    input wire logic i_hblank_start,
    input wire logic [7:0] o_luma,
    input wire tav_pkg::tav_sync_t o_sync,
    input wire logic o_video_oe_b,
    input wire logic o_busy
);
    int cnt;
    logic run;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // run masks the first edge, where past values are still from reset
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 0;
            run <= 1'b0;
        end else begin
            cnt <= o_busy ? cnt + 1 : 0;
            run <= 1'b1;
        end
    end
    sync_pass_a: assert property (run |-> o_sync == $past(i_sync))
        else $error("sync not passed through");
    idle_pass_a: assert property (run && !o_busy |-> o_luma == $past(i_luma))
        else $error("luma not passed through");
    reset_float_a: assert property (@(posedge i_ref_clk) disable iff (1'b0)
        !i_rst_b |-> o_video_oe_b && !o_busy) else $error("outputs driven in reset");
    oe_release_a: assert property ($fell(o_video_oe_b) |->
        $past(i_hblank_start) || $past(i_hblank_start, 2)) else $error("early drive");
    preamble_a: assert property ($rose(o_busy) |-> o_luma == 8'h00 ##1 o_luma == 8'hFF
        ##1 o_luma == 8'hFF ##2 o_luma == 8'h80) else $error("bad preamble");
    did_parity_a: assert property ($rose(o_busy) |-> ##3 (o_luma[5:3] == 3'h2 &&
        o_luma[6] == ^o_luma[5:0] && o_luma[7] != o_luma[6])) else $error("bad id byte");
    word_count_a: assert property ($rose(o_busy) |-> ##5
        (o_luma == 8'h4B || o_luma == 8'h80)) else $error("bad word count");
    burst_len_a: assert property ($fell(o_busy) |-> cnt == 6 || cnt == 52)
        else $error("bad packet length");
    fill_byte_a: assert property ($fell(o_busy) |-> $past(o_luma) == 8'h80)
        else $error("bad last byte");
endmodule
bind tav_inserter tav_inserter_asserts u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_luma(i_luma), .i_sync(i_sync), .i_hblank_start(i_hblank_start), .o_luma(o_luma),
    .o_sync(o_sync), .o_video_oe_b(o_video_oe_b), .o_busy(o_busy));

/* tb_teletext_ancillary_packet_inserter.sv */
/*
 testbench: feeds sliced lines and blanking pulses, checks packets.
 assumes tav_rx_model keeps packet bytes in arrival order.
*/
`timescale 1ns/1ps
module tb_teletext_ancillary_packet_inserter;
    // reset starts high so the first low drive is a real falling edge
    logic i_ref_clk = 1'b0, i_rst_b = 1'b1, i_field = 1'b0, i_hblank_start = 1'b0;
    logic i_ttx_done = 1'b0, o_video_oe_b, o_busy;
    logic [7:0] i_luma = 8'h00, o_luma;
    logic [8:0] i_line_done = 9'h000;
    tav_pkg::tav_sync_t i_sync = 3'h0, o_sync;
    tav_pkg::tav_ttx_wr_t i_ttx_wr = 15'h0000;
    tav_pkg::tav_ttx_meta_t i_ttx_meta = 14'h0000;
    int num_errors = 0, n_checks = 0;
    tav_inserter uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_luma(i_luma),
        .i_sync(i_sync), .i_field(i_field), .i_hblank_start(i_hblank_start),
        .i_line_done(i_line_done), .i_ttx_wr(i_ttx_wr), .i_ttx_done(i_ttx_done),
        .i_ttx_meta(i_ttx_meta), .o_luma(o_luma), .o_sync(o_sync),
        .o_video_oe_b(o_video_oe_b), .o_busy(o_busy));
    tav_rx_model u_rx (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_luma(o_luma),
        .i_busy(o_busy));
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // moving picture data so a stale pass-through shows up
    always @(posedge i_ref_clk) begin
        i_luma <= i_luma + 8'h01;
        i_sync <= i_sync + 3'h1;
    end
    function automatic logic [7:0] par(input logic [5:0] v);
        return {~^v, ^v, v};
    endfunction
    function automatic logic [7:0] pay(input int k, input logic [8:0] ln);
        return 8'(k * 7) + ln[7:0] + 8'h3C;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic hold_reset;
        i_rst_b <= 1'b0;
        repeat (10) @(posedge i_ref_clk);
        chk({7'h00, o_video_oe_b}, 8'h01);
        chk({7'h00, o_busy}, 8'h00);
        chk(o_luma, 8'h00);
        i_rst_b <= 1'b1;
        @(posedge i_ref_clk);
        chk({7'h00, o_video_oe_b}, 8'h01);
    endtask
    // one sliced line when tt is set, then its blanking; nb is the byte count expected
    task automatic run_line(input logic f, input logic [8:0] ln, input bit tt, input int nb,
        output int b);
        int k;
        b = u_rx.wp;
        if (tt) begin
            for (k = 0; k < 42; k++) begin
                @(posedge i_ref_clk);
                i_ttx_wr <= {1'b1, 6'(k), pay(k, ln)};
            end
            @(posedge i_ref_clk);
            i_ttx_wr <= 15'h0000;
            i_ttx_meta <= {ln, ln[4:0]};
            i_ttx_done <= 1'b1;
            @(posedge i_ref_clk);
            i_ttx_done <= 1'b0;
        end
        @(posedge i_ref_clk);
        i_field <= f;
        i_line_done <= ln;
        i_hblank_start <= 1'b1;
        @(posedge i_ref_clk);
        i_hblank_start <= 1'b0;
        for (k = 0; k < 200 && u_rx.wp < b + nb; k++) @(posedge i_ref_clk);
        repeat (8) @(posedge i_ref_clk);
        chk(8'(u_rx.wp - b), 8'(nb));
    endtask
    task automatic head(input int b, input logic f, input logic [1:0] ty);
        chk(u_rx.mem[b], 8'h00);
        chk(u_rx.mem[b+1], 8'hFF);
        chk(u_rx.mem[b+2], 8'hFF);
        chk(u_rx.mem[b+3], par({3'h2, f, ty}));
        chk(u_rx.mem[b+4], 8'h80);
    endtask
    task automatic dum(input int b, input logic f, input logic [1:0] ty);
        head(b, f, ty);
        chk(u_rx.mem[b+5], 8'h80);
    endtask
    task automatic ttx(input int b, input logic f, input logic [8:0] ln);
        logic [7:0] s;
        int k;
        s = 8'h00;
        head(b, f, ln <= 9'h017 ? 2'h1 : 2'h3);
        chk(u_rx.mem[b+5], 8'h4B);
        chk(u_rx.mem[b+6], ln[7:0]);
        chk(u_rx.mem[b+7], {2'h0, ln[4:0], ln[8]});
        for (k = 0; k < 42; k++) begin
            chk(u_rx.mem[b+8+k], pay(k, ln));
            s = s + pay(k, ln);
        end
        chk(u_rx.mem[b+50], par(s[5:0]));
        chk(u_rx.mem[b+51], 8'h80);
    endtask
    task automatic s_odd;
        int b;
        run_line(1'b0, 9'h00A, 1, 58, b);
        dum(b, 1'b0, 2'h0);
        ttx(b + 6, 1'b0, 9'h00A);
        chk({7'h00, o_video_oe_b}, 8'h00);
        run_line(1'b0, 9'h017, 1, 58, b);
        ttx(b, 1'b0, 9'h017);
        dum(b + 52, 1'b0, 2'h2);
        run_line(1'b0, 9'h064, 1, 52, b);
        ttx(b, 1'b0, 9'h064);
        $display("odd field done");
    endtask
    task automatic s_even;
        int b;
        run_line(1'b1, 9'h005, 1, 58, b);
        dum(b, 1'b1, 2'h0);
        ttx(b + 6, 1'b1, 9'h005);
        run_line(1'b1, 9'h017, 0, 6, b);
        dum(b, 1'b1, 2'h2);
        run_line(1'b1, 9'h12C, 1, 52, b);
        ttx(b, 1'b1, 9'h12C);
        $display("even field done");
    endtask
    task automatic s_reset;
        int b;
        hold_reset();
        run_line(1'b1, 9'h12C, 0, 6, b);
        dum(b, 1'b1, 2'h0);
        $display("mid-run reset done");
    endtask
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        num_errors++;
        conclude();
    end
    initial begin
        hold_reset();
        s_odd();
        s_even();
        s_reset();
        conclude();
    end
endmodule
